//--- hw/exec_pkg.sv
package exec_pkg;

    // datapath widths
    localparam int DATA_W    = 32;
    localparam int HALF_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int IMM_W     = 16;
    localparam int LANES     = 4;
    localparam int PROD_W    = 64;
    localparam int REG_IDX_W = 5;

    // iterative divider: one quotient bit per clock
    localparam int DIV_STEPS = 32;
    localparam int DIV_CNT_W = 6;

    // reset values and byte-lane masks per access size
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [3:0]  BE_RST   = 4'h0;
    localparam logic [3:0]  BE_WORD  = 4'hf;
    localparam logic [3:0]  BE_HALF  = 4'h3;
    localparam logic [3:0]  BE_BYTE  = 4'h1;

    // quotient magnitude returned for a zero divisor
    localparam logic [31:0] DIV_ZERO_Q = 32'hffff_ffff;

    // operations handed over by the decoder
    typedef enum logic [5:0] {
        OP_LOAD_WORD, OP_LOAD_BYTE_S, OP_LOAD_BYTE_U, OP_LOAD_HALF_S, OP_LOAD_HALF_U,
        OP_STORE_WORD, OP_STORE_BYTE, OP_STORE_HALF,
        OP_AND, OP_OR, OP_XOR, OP_NOR,
        OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM,
        OP_AND_HIGH, OP_OR_HIGH, OP_XOR_HIGH,
        OP_ADD, OP_SUB, OP_MUL, OP_DIV_S, OP_DIV_U,
        OP_ADD_IMM, OP_SUB_IMM, OP_MUL_IMM,
        OP_MULH_SS, OP_MULH_UU, OP_MULH_SU,
        OP_MOVE, OP_MOVE_IMM_S, OP_MOVE_IMM_U, OP_MOVE_HIGH, OP_MOVE_ADDR
    } op_e;

endpackage

//--- hw/load_store_alu_move_exec.sv
// Overview of operation
// - only loads and stores touch the bus; other ops use registers and immediates
// - memory and peripherals are reached through one shared address space
// - word load/store moves 32 bits at base register plus signed immediate
// - normal stores may be posted, so bus cycles need not follow program order
// - uncached word accesses bypass buffering, issue in order, never suppressed
// - signed byte/half loads sign-extend, unsigned ones zero-extend to 32 bits
// - byte store writes the low byte, half store the low half
// - uncached byte/half accesses bypass buffering, same extension as cached ones
// - and, or, xor, nor combine two 32-bit registers bitwise
// - immediate and/or/xor zero-extend the 16-bit immediate
// - high and/or/xor shift the immediate left 16, zero low half
// - add, sub, mul, signed and unsigned divide take two 32-bit registers
// - immediate add, sub, mul use a signed 16-bit immediate
// - signed and unsigned high multiplies return the upper 32 product bits
// - high multiply computes alone, needing no earlier low multiply
// - mixed-sign high multiply gives the partial product for 64x64 signed work
// - register move copies the source unchanged
// - signed immediate move sign-extends 16 bits to 32
// - unsigned immediate move fills low half, high move upper half, rest zero
// - address move leaves a complete 32-bit address in the destination
// - multi-byte data is little-endian: low bytes at low addresses
// - the data bus is 32 bits wide
`timescale 1ns/100ps
`default_nettype none

module load_store_alu_move_exec #(
    parameter int DIV_STEPS = exec_pkg::DIV_STEPS
) (
    input  wire logic                 clk,           // core clock
    input  wire logic                 rst_n,         // async reset, active low
    input  wire logic                 opValid,       // decoder offers an operation
    input  wire exec_pkg::op_e        opCode,        // operation
    input  wire logic                 opUncached,    // io variant of a load or store
    input  wire logic [31:0]          srcA,          // first source register / base
    input  wire logic [31:0]          srcB,          // second source / store data / address
    input  wire logic [15:0]          imm16,         // immediate field
    input  wire logic [4:0]           opDest,        // destination register index
    output logic                      opReady,       // operation may be taken
    output logic                      resultValid,   // register write-back pulse
    output logic [31:0]               result,        // write-back value
    output logic [4:0]                resultDest,    // write-back register index
    output logic                      busRead,       // read request
    output logic                      busWrite,      // write request
    output logic [31:0]               busAddr,       // byte address
    output logic [3:0]                busByteEn,     // byte lanes
    output logic [31:0]               busWriteData,  // write data, lane aligned
    output logic                      busUncached,   // access must bypass caches
    input  wire logic                 busWaitreq,    // slave holds the request
    input  wire logic [31:0]          busReadData    // read data, valid when read taken
);

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_BUS, ST_DIV} state_e;

    // sign-extend a 16-bit field
    function automatic logic [31:0] signExt16(input logic [15:0] v);
        return {{exec_pkg::HALF_W{v[15]}}, v};
    endfunction

    // full product with per-operand signedness
    function automatic logic [63:0] product(input logic [31:0] a, input logic [31:0] b,
                                            input logic aSigned, input logic bSigned);
        logic signed [32:0] ea;
        logic signed [32:0] eb;
        logic signed [65:0] p;
        ea = {aSigned & a[31], a};
        eb = {bSigned & b[31], b};
        p  = ea * eb;
        return p[63:0];
    endfunction

    // two's-complement magnitude
    function automatic logic [31:0] magnitude(input logic [31:0] v, input logic isSigned);
        return (isSigned && v[31]) ? 32'(-v) : v;
    endfunction

    // byte lanes for an access size at a byte address
    function automatic logic [3:0] laneMask(input logic [3:0] sizeMask, input logic [1:0] a);
        return 4'(sizeMask << a);
    endfunction

    // pick and extend load data from its lanes
    function automatic logic [31:0] extractLoad(input exec_pkg::op_e k, input logic [31:0] d,
                                                input logic [1:0] a);
        logic [31:0] s;
        s = d >> {a, 3'b000};
        unique case (k)
            exec_pkg::OP_LOAD_BYTE_S: return {{24{s[7]}}, s[7:0]};
            exec_pkg::OP_LOAD_BYTE_U: return {24'h000000, s[7:0]};
            exec_pkg::OP_LOAD_HALF_S: return signExt16(s[15:0]);
            exec_pkg::OP_LOAD_HALF_U: return {16'h0000, s[15:0]};
            default:                  return d;
        endcase
    endfunction

    // state
    state_e         state, next_state;
    logic           next_opReady, next_resultValid, next_busRead, next_busWrite;
    logic           next_busUncached;
    logic [31:0]    next_result, next_busAddr, next_busWriteData;
    logic [4:0]     next_resultDest;
    logic [3:0]     next_busByteEn;
    // captured memory request, launched once the bus is free
    exec_pkg::op_e  reqKind, next_reqKind;
    logic           reqWrite, next_reqWrite, reqUncached, next_reqUncached;
    logic [31:0]    reqAddr, next_reqAddr, reqData, next_reqData;
    logic [3:0]     reqBe, next_reqBe;
    logic [4:0]     reqDest, next_reqDest;
    // divider
    logic [32:0]    divRem, next_divRem;
    logic [31:0]    divQuot, next_divQuot, divisor, next_divisor;
    logic [5:0]     divCnt, next_divCnt;
    logic           divNeg, next_divNeg, divZero, next_divZero;

    // operand and result selection for single-cycle ops
    logic [31:0] operandB, aluOut, effAddr;
    logic [63:0] prod;
    logic        isMem, isStore;

    always_comb begin
        unique case (opCode)
            exec_pkg::OP_AND_IMM, exec_pkg::OP_OR_IMM, exec_pkg::OP_XOR_IMM:
                operandB = {16'h0000, imm16};
            exec_pkg::OP_AND_HIGH, exec_pkg::OP_OR_HIGH, exec_pkg::OP_XOR_HIGH:
                operandB = {imm16, 16'h0000};
            exec_pkg::OP_ADD_IMM, exec_pkg::OP_SUB_IMM, exec_pkg::OP_MUL_IMM:
                operandB = signExt16(imm16);
            default:
                operandB = srcB;
        endcase
    end

    // each high multiply forms its own full product; nothing is kept between ops
    always_comb begin
        unique case (opCode)
            exec_pkg::OP_MULH_SS: prod = product(srcA, srcB, 1'b1, 1'b1);
            exec_pkg::OP_MULH_UU: prod = product(srcA, srcB, 1'b0, 1'b0);
            exec_pkg::OP_MULH_SU: prod = product(srcA, srcB, 1'b1, 1'b0);
            default:              prod = product(srcA, operandB, 1'b0, 1'b0);
        endcase
    end

    // register-only results; no bus involvement here
    always_comb begin
        unique case (opCode)
            exec_pkg::OP_AND, exec_pkg::OP_AND_IMM, exec_pkg::OP_AND_HIGH:
                aluOut = srcA & operandB;
            exec_pkg::OP_OR, exec_pkg::OP_OR_IMM, exec_pkg::OP_OR_HIGH:
                aluOut = srcA | operandB;
            exec_pkg::OP_XOR, exec_pkg::OP_XOR_IMM, exec_pkg::OP_XOR_HIGH:
                aluOut = srcA ^ operandB;
            exec_pkg::OP_NOR:                             aluOut = ~(srcA | srcB);
            exec_pkg::OP_ADD, exec_pkg::OP_ADD_IMM:       aluOut = srcA + operandB;
            exec_pkg::OP_SUB, exec_pkg::OP_SUB_IMM:       aluOut = srcA - operandB;
            exec_pkg::OP_MUL, exec_pkg::OP_MUL_IMM:       aluOut = prod[31:0];
            exec_pkg::OP_MULH_SS, exec_pkg::OP_MULH_UU, exec_pkg::OP_MULH_SU:
                aluOut = prod[63:32];
            exec_pkg::OP_MOVE:                            aluOut = srcA;
            exec_pkg::OP_MOVE_IMM_S:                      aluOut = signExt16(imm16);
            exec_pkg::OP_MOVE_IMM_U:                      aluOut = {16'h0000, imm16};
            exec_pkg::OP_MOVE_HIGH:                       aluOut = {imm16, 16'h0000};
            exec_pkg::OP_MOVE_ADDR:                       aluOut = srcB;
            default:                                      aluOut = exec_pkg::DATA_RST;
        endcase
    end

    // only loads and stores ever reach the bus
    always_comb begin
        isStore = (opCode == exec_pkg::OP_STORE_WORD) || (opCode == exec_pkg::OP_STORE_BYTE)
               || (opCode == exec_pkg::OP_STORE_HALF);
        isMem   = isStore || (opCode == exec_pkg::OP_LOAD_WORD)
               || (opCode == exec_pkg::OP_LOAD_BYTE_S) || (opCode == exec_pkg::OP_LOAD_BYTE_U)
               || (opCode == exec_pkg::OP_LOAD_HALF_S) || (opCode == exec_pkg::OP_LOAD_HALF_U);
        effAddr = srcA + signExt16(imm16);
    end

    // main sequencer, bus master and divider
    always_comb begin
        logic [32:0] trial;
        logic [31:0] q;
        logic [31:0] ma;
        logic [31:0] mb;
        logic        busFree;
        logic        sgn;
        trial = 33'h0_0000_0000;
        q     = exec_pkg::DATA_RST;
        ma    = exec_pkg::DATA_RST;
        mb    = exec_pkg::DATA_RST;
        sgn   = 1'b0;
        busFree = !(busRead || busWrite) || !busWaitreq;
        next_state        = state;
        next_resultValid  = 1'b0;
        next_result       = result;
        next_resultDest   = resultDest;
        next_busRead      = busRead;
        next_busWrite     = busWrite;
        next_busAddr      = busAddr;
        next_busByteEn    = busByteEn;
        next_busWriteData = busWriteData;
        next_busUncached  = busUncached;
        next_reqKind      = reqKind;
        next_reqWrite     = reqWrite;
        next_reqUncached  = reqUncached;
        next_reqAddr      = reqAddr;
        next_reqData      = reqData;
        next_reqBe        = reqBe;
        next_reqDest      = reqDest;
        next_divRem       = divRem;
        next_divQuot      = divQuot;
        next_divisor      = divisor;
        next_divCnt       = divCnt;
        next_divNeg       = divNeg;
        next_divZero      = divZero;

        // a request leaves the bus when the slave stops holding it
        if ((busRead || busWrite) && !busWaitreq) begin
            next_busRead  = 1'b0;
            next_busWrite = 1'b0;
        end

        unique case (state)
            ST_IDLE: begin
                if (opValid && isMem) begin
                    next_reqKind     = opCode;
                    next_reqWrite    = isStore;
                    next_reqUncached = opUncached;
                    next_reqAddr     = effAddr;
                    next_reqDest     = opDest;
                    unique case (opCode)
                        exec_pkg::OP_STORE_BYTE, exec_pkg::OP_LOAD_BYTE_S,
                        exec_pkg::OP_LOAD_BYTE_U:
                            next_reqBe = laneMask(exec_pkg::BE_BYTE, effAddr[1:0]);
                        exec_pkg::OP_STORE_HALF, exec_pkg::OP_LOAD_HALF_S,
                        exec_pkg::OP_LOAD_HALF_U:
                            next_reqBe = laneMask(exec_pkg::BE_HALF, effAddr[1:0]);
                        default:
                            next_reqBe = exec_pkg::BE_WORD;
                    endcase
                    // low bits shifted into the addressed lanes
                    next_reqData = 32'(srcB << {effAddr[1:0], 3'b000});
                    next_state   = ST_ISSUE;
                end else if (opValid && (opCode == exec_pkg::OP_DIV_S
                                         || opCode == exec_pkg::OP_DIV_U)) begin
                    sgn          = (opCode == exec_pkg::OP_DIV_S);
                    ma           = magnitude(srcA, sgn);
                    mb           = magnitude(srcB, sgn);
                    next_divRem  = 33'h0_0000_0000;
                    next_divQuot = ma;
                    next_divisor = mb;
                    next_divNeg  = sgn && (srcA[31] ^ srcB[31]);
                    next_divZero = (srcB == exec_pkg::DATA_RST);
                    next_divCnt  = 6'(DIV_STEPS);
                    next_reqDest = opDest;
                    next_state   = ST_DIV;
                end else if (opValid) begin
                    next_resultValid = 1'b1;
                    next_result      = aluOut;
                    next_resultDest  = opDest;
                end
            end
            ST_ISSUE: begin
                // one outstanding bus request at a time; a posted store is drained first
                if (busFree) begin
                    next_busRead      = !reqWrite;
                    next_busWrite     = reqWrite;
                    next_busAddr      = reqAddr;
                    next_busByteEn    = reqBe;
                    next_busWriteData = reqData;
                    next_busUncached  = reqUncached;
                    // cached stores are posted; uncached ones wait for the slave
                    next_state = (reqWrite && !reqUncached) ? ST_IDLE : ST_BUS;
                end
            end
            ST_BUS: begin
                if (!busWaitreq) begin
                    if (busRead) begin
                        next_resultValid = 1'b1;
                        next_result      = extractLoad(reqKind, busReadData, busAddr[1:0]);
                        next_resultDest  = reqDest;
                    end
                    next_state = ST_IDLE;
                end
            end
            ST_DIV: begin
                // restoring division on magnitudes, one bit a clock
                trial = {divRem[31:0], divQuot[31]};
                q     = {divQuot[30:0], 1'b0};
                if (trial >= {1'b0, divisor}) begin
                    trial = 33'(trial - {1'b0, divisor});
                    q[0]  = 1'b1;
                end
                next_divRem  = trial;
                next_divQuot = q;
                next_divCnt  = 6'(divCnt - 6'h01);
                if (divCnt == 6'h01) begin
                    if (divZero) begin
                        q = exec_pkg::DIV_ZERO_Q;
                    end
                    next_resultValid = 1'b1;
                    next_result      = divNeg ? 32'(-q) : q;
                    next_resultDest  = reqDest;
                    next_state       = ST_IDLE;
                end
            end
        endcase
        next_opReady = (next_state == ST_IDLE);
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_IDLE;
            opReady      <= 1'b0;
            resultValid  <= 1'b0;
            result       <= exec_pkg::DATA_RST;
            resultDest   <= 5'h00;
            busRead      <= 1'b0;
            busWrite     <= 1'b0;
            busAddr      <= exec_pkg::DATA_RST;
            busByteEn    <= exec_pkg::BE_RST;
            busWriteData <= exec_pkg::DATA_RST;
            busUncached  <= 1'b0;
            reqKind      <= exec_pkg::OP_LOAD_WORD;
            reqWrite     <= 1'b0;
            reqUncached  <= 1'b0;
            reqAddr      <= exec_pkg::DATA_RST;
            reqData      <= exec_pkg::DATA_RST;
            reqBe        <= exec_pkg::BE_RST;
            reqDest      <= 5'h00;
            divRem       <= 33'h0_0000_0000;
            divQuot      <= exec_pkg::DATA_RST;
            divisor      <= exec_pkg::DATA_RST;
            divCnt       <= 6'h00;
            divNeg       <= 1'b0;
            divZero      <= 1'b0;
        end else begin
            state        <= next_state;
            opReady      <= next_opReady;
            resultValid  <= next_resultValid;
            result       <= next_result;
            resultDest   <= next_resultDest;
            busRead      <= next_busRead;
            busWrite     <= next_busWrite;
            busAddr      <= next_busAddr;
            busByteEn    <= next_busByteEn;
            busWriteData <= next_busWriteData;
            busUncached  <= next_busUncached;
            reqKind      <= next_reqKind;
            reqWrite     <= next_reqWrite;
            reqUncached  <= next_reqUncached;
            reqAddr      <= next_reqAddr;
            reqData      <= next_reqData;
            reqBe        <= next_reqBe;
            reqDest      <= next_reqDest;
            divRem       <= next_divRem;
            divQuot      <= next_divQuot;
            divisor      <= next_divisor;
            divCnt       <= next_divCnt;
            divNeg       <= next_divNeg;
            divZero      <= next_divZero;
        end
    end

endmodule

`default_nettype wire

//--- tb/exec_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module exec_asserts #(
    parameter int DIV_STEPS = 32
) (
    input  wire logic           clk,          // core clock
    input  wire logic           rst_n,        // reset, active low
    input  wire logic           opValid,      // op offered
    input  wire exec_pkg::op_e  opCode,       // operation
    input  wire logic           opReady,      // op may be taken
    input  wire logic [31:0]    srcA,         // first operand
    input  wire logic [31:0]    srcB,         // second operand
    input  wire logic [15:0]    imm16,        // immediate
    input  wire logic           resultValid,  // write-back pulse
    input  wire logic [31:0]    result,       // write-back value
    input  wire logic           busRead,      // read request
    input  wire logic           busWrite,     // write request
    input  wire logic           busUncached,  // io access
    input  wire logic [31:0]    busAddr,      // byte address
    input  wire logic [31:0]    busWriteData, // write data
    input  wire logic           busWaitreq    // slave stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // product of the operands as offered
    wire logic        take = opValid && opReady;
    wire logic [63:0] prodUU = {32'h0, srcA} * {32'h0, srcB};

    chk_read_hold: assert property (busRead && busWaitreq |=> busRead && $stable(busAddr))
        else $error("read dropped in stall");
    chk_write_hold: assert property (busWrite && busWaitreq |=> busWrite && $stable(busWriteData))
        else $error("write dropped in stall");
    chk_one_access: assert property (!(busRead && busWrite))
        else $error("read and write at once");
    chk_read_busy: assert property (busRead |-> !opReady)
        else $error("op taken during read");
    chk_io_write_wait: assert property (busWrite && busUncached |-> !opReady)
        else $error("uncached write was posted");
    chk_add_sum: assert property (take && opCode == exec_pkg::OP_ADD |=>
        resultValid && result == $past(srcA) + $past(srcB)) else $error("add result wrong");
    chk_andi_zext: assert property (take && opCode == exec_pkg::OP_AND_IMM |=>
        result == ($past(srcA) & {16'h0000, $past(imm16)})) else $error("andi result wrong");
    chk_movhi_place: assert property (take && opCode == exec_pkg::OP_MOVE_HIGH |=>
        result == {$past(imm16), 16'h0000}) else $error("high move wrong");
    chk_mulh_upper: assert property (take && opCode == exec_pkg::OP_MULH_UU |=>
        result == $past(prodUU[63:32])) else $error("high multiply wrong");
    chk_div_busy: assert property (take && opCode == exec_pkg::OP_DIV_U |=> !opReady [*8])
        else $error("divide let an op in");
    // main scenarios reached
    cover property (busRead && busWaitreq);
    cover property (take && opCode == exec_pkg::OP_DIV_S);
    cover property (busWrite && !busUncached && busWaitreq);
endmodule
`default_nettype wire

//--- tb/exec_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module exec_mem_model (
    input  wire logic        clk,          // core clock
    input  wire logic        rst_n,        // reset, active low
    input  wire logic        slow,         // stall every request
    input  wire logic        busRead,      // read request
    input  wire logic        busWrite,     // write request
    input  wire logic [31:0] busAddr,      // byte address
    input  wire logic [3:0]  busByteEn,    // byte lanes
    input  wire logic [31:0] busWriteData, // write data
    output logic             busWaitreq,   // hold request
    output logic [31:0]      busReadData   // read data
);
    logic [31:0] mem [16];
    logic [1:0]  waits;
    wire logic   req = busRead | busWrite;
    // slow mode stalls two cycles per request
    assign busWaitreq = req && slow && waits != 2'd2;
    // data off the bus is inverted so a stale sample never matches
    assign busReadData = busRead ? mem[busAddr[5:2]] : ~mem[busAddr[5:2]];
    // memory and stall counter; lanes land little-endian
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waits <= 2'd0;
            for (int i = 0; i < 16; i++) mem[i] <= 32'h9e37_79b9 * 32'(i + 1);
        end else if (req && !busWaitreq) begin
            waits <= 2'd0;
            for (int l = 0; l < 4; l++)
                if (busWrite && busByteEn[l]) mem[busAddr[5:2]][8*l +: 8] <= busWriteData[8*l +: 8];
        end else if (req) begin
            waits <= waits + 2'd1;
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    logic clk, rst_n, slow, opValid, opUncached, expUnc;
    exec_pkg::op_e op, opCode;
    logic [31:0] srcA, srcB, seed, a, b, d, r, e, v, adr, base, sh [16];
    logic [15:0] imm16, im;
    logic [4:0]  opDest, resultDest;
    logic [3:0]  busByteEn;
    logic [31:0] result, busAddr, busWriteData, busReadData;
    logic opReady, resultValid, busRead, busWrite, busUncached, busWaitreq;
    int n_fail = 0, comparisons = 0, k, sz, nb;
    load_store_alu_move_exec u_dut (.*);
    exec_mem_model u_mem (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction
    // reference results for register-only ops
    function automatic logic [31:0] alu_exp(exec_pkg::op_e o, logic [31:0] x, y, logic [15:0] i);
        logic [31:0] s, z, h;
        s = {{16{i[15]}}, i};
        z = {16'h0, i};
        h = {i, 16'h0};
        if (y == 0 && (o == exec_pkg::OP_DIV_S || o == exec_pkg::OP_DIV_U))
            return (o == exec_pkg::OP_DIV_S && x[31]) ? 32'h1 : exec_pkg::DIV_ZERO_Q;
        case (o)
            exec_pkg::OP_AND: return x & y;
            exec_pkg::OP_OR: return x | y;
            exec_pkg::OP_XOR: return x ^ y;
            exec_pkg::OP_NOR: return ~(x | y);
            exec_pkg::OP_AND_IMM: return x & z;
            exec_pkg::OP_OR_IMM: return x | z;
            exec_pkg::OP_XOR_IMM: return x ^ z;
            exec_pkg::OP_AND_HIGH: return x & h;
            exec_pkg::OP_OR_HIGH: return x | h;
            exec_pkg::OP_XOR_HIGH: return x ^ h;
            exec_pkg::OP_ADD: return x + y;
            exec_pkg::OP_SUB: return x - y;
            exec_pkg::OP_MUL: return x * y;
            exec_pkg::OP_DIV_S: return $signed(x) / $signed(y);
            exec_pkg::OP_DIV_U: return x / y;
            exec_pkg::OP_ADD_IMM: return x + s;
            exec_pkg::OP_SUB_IMM: return x - s;
            exec_pkg::OP_MUL_IMM: return x * s;
            exec_pkg::OP_MULH_SS: return 32'(({{32{x[31]}}, x} * {{32{y[31]}}, y}) >> 32);
            exec_pkg::OP_MULH_UU: return 32'(({32'h0, x} * {32'h0, y}) >> 32);
            exec_pkg::OP_MULH_SU: return 32'(({{32{x[31]}}, x} * {32'h0, y}) >> 32);
            exec_pkg::OP_MOVE: return x;
            exec_pkg::OP_MOVE_IMM_S: return s;
            exec_pkg::OP_MOVE_IMM_U: return z;
            exec_pkg::OP_MOVE_HIGH: return h;
            default: return y;
        endcase
    endfunction
    // offer one op until taken; then its result, or one edge so opValid drops cleanly
    task automatic run(exec_pkg::op_e o, logic [31:0] x, y, logic [15:0] i, logic u, logic want);
        opValid <= 1'b1; opCode <= o; srcA <= x; srcB <= y; imm16 <= i;
        opUncached <= u; opDest <= 5'(rnd());
        do @(posedge clk); while (opReady !== 1'b1);
        opValid <= 1'b0;
        if (want) begin
            do @(posedge clk); while (resultValid !== 1'b1);
            r = result;
            `CHK(resultDest, opDest)
        end else @(posedge clk);
    endtask
    task complete_run;
        $display("comparisons %0d failures %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // every accepted bus cycle goes to the expected address and cache class
    always @(posedge clk) begin
        if ((busRead | busWrite) && !busWaitreq)
            `CHK({busAddr, busUncached}, {adr, expUnc})
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        n_fail++;
        complete_run;
    end
    initial begin
        rst_n = 1'b0; slow = 1'b0; opValid = 1'b0; opUncached = 1'b0; opCode = exec_pkg::OP_ADD;
        srcA = 32'h0; srcB = 32'h0; imm16 = 16'h0; opDest = 5'h0; seed = 32'd67577;
        for (int i = 0; i < 16; i++) sh[i] = 32'h9e37_79b9 * 32'(i + 1);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // all register ops: sign corners, zero divisor, then random
        for (int n = 0; n < 200; n++) begin
            op = exec_pkg::op_e'(8 + n % 26);
            a = rnd(); b = rnd(); im = 16'(rnd());
            if (n < 26) begin a = 32'h8000_0001; b = 32'hffff_fffe; im = 16'h8000; end
            if (n >= 26 && n < 52) b = 32'h0;
            run(op, a, b, im, 1'b0, 1'b1);
            `CHK(r, alu_exp(op, a, b, im))
        end
        $display("register op test done");
        // store one size then load back any size, stalls and io mixed in
        for (int n = 0; n < 150; n++) begin
            sz = n % 3; k = (n / 3) % 5; slow <= 1'(rnd());
            adr = rnd(); im = 16'(rnd()); d = rnd(); expUnc = 1'(rnd());
            if (sz == 0 || k == 0) adr[1:0] = 2'b00;
            else if (sz == 2 || k > 2) adr[0] = 1'b0;
            base = adr - {{16{im[15]}}, im};
            nb = sz == 0 ? 4 : sz == 1 ? 1 : 2;
            for (int j = 0; j < nb; j++) sh[adr[5:2]][8*(adr[1:0] + j) +: 8] = d[8*j +: 8];
            run(exec_pkg::op_e'(5 + sz), base, d, im, expUnc, 1'b0);
            run(exec_pkg::op_e'(k), base, rnd(), im, expUnc, 1'b1);
            v = sh[adr[5:2]] >> (8 * adr[1:0]);
            case (k)
                0: e = v;
                1: e = {{24{v[7]}}, v[7:0]};
                2: e = {24'h0, v[7:0]};
                3: e = {{16{v[15]}}, v[15:0]};
                default: e = {16'h0, v[15:0]};
            endcase
            `CHK(r, e)
        end
        $display("memory test done");
        complete_run;
    end
endmodule
bind load_store_alu_move_exec exec_asserts #(.DIV_STEPS(DIV_STEPS)) u_chk (.*);
`default_nettype wire
